// [inc/pwr_seq_pkg.sv]
package pwr_seq_pkg;
    // wake-up delay in microseconds once nmi ends power-down
    localparam int WAKE_DELAY_US = 100;
    localparam int CLK_MHZ = 100;
    localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    // pin states and reset values
    localparam logic BIT_SET = 1'h1;
    localparam logic BIT_CLR = 1'h0;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [2:0] SYNC_HIGH = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PDOWN,
        ST_WAKE
    } pwr_state_t;
endpackage

// [logic/powerdown_reset_sequencer.sv]
// Functional notes
// (RULE1) power-down entered only when enable bit is 1 and halt executes
// (RULE2) power-down ends on nmi assertion or external reset assertion
// (RULE3) nmi exit keeps clocks gated for the wake delay, then resumes
// (RULE4) reset exit skips the wake delay entirely
// (RULE5) reset low aborts bus cycle at once and initialises the core
// (RULE6) during reset all pins go to known levels; indicator asserted
// (RULE7) reset indicator stays high while reset input is low
// (RULE8) short nmi pulses are latched as wake and interrupt events
// (RULE9) test-mode pin low during reset floats all outputs
// (RULE10) clocks stay gated with state kept throughout power-down
module powerdown_reset_sequencer #(
    parameter int WAKE_COUNT = pwr_seq_pkg::WAKE_CYCLES
) (
    input wire logic core_clk_i, // system clock, 100 MHz
    input wire logic rstn_i, // synchronous reset, active low
    input wire logic resin_n_i, // external reset pin, active low
    input wire logic nmi_i, // non-maskable interrupt pin, active high
    input wire logic test_mode_n_i, // test-mode pin, active low
    input wire logic powerdown_enable_bit_i, // power control enable bit
    input wire logic halt_exec_i, // pulse: halt instruction executed
    input wire logic nmi_ack_i, // pulse: core took the nmi
    output logic core_clk_en_o, // internal clock enable
    output logic bus_abort_o, // abort bus cycle in progress
    output logic core_init_o, // hold core in initialised state
    output logic reset_out_o, // reset indicator, active high
    output logic pins_float_o, // all output pins high impedance
    output logic nmi_pending_o, // latched nmi event
    output logic in_powerdown_o // power-down or wake delay active
);
    import pwr_seq_pkg::*;

    logic [2:0] resin_sync_r, resin_sync_nxt;
    logic [2:0] nmi_sync_r, nmi_sync_nxt;
    logic [2:0] test_sync_r, test_sync_nxt;
    logic resin_n_r, resin_n_nxt;
    logic nmi_r, nmi_nxt;
    logic test_n_r, test_n_nxt;
    logic nmi_prev_r, nmi_prev_nxt;
    logic nmi_latch_r, nmi_latch_nxt;
    logic float_r, float_nxt;
    logic reset_out_r, reset_out_nxt;
    pwr_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic in_reset;
    logic nmi_rise;

    localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_COUNT);

    // filtered pin level: change once second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic cur);
        filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    assign in_reset = !rstn_i || !resin_n_r;
    assign nmi_rise = nmi_r && !nmi_prev_r;

    // pin synchronisers and filters
    always_comb begin
        resin_sync_nxt = {resin_sync_r[1:0], resin_n_i};
        nmi_sync_nxt = {nmi_sync_r[1:0], nmi_i};
        test_sync_nxt = {test_sync_r[1:0], test_mode_n_i};
        resin_n_nxt = filt(resin_sync_r, resin_n_r);
        nmi_nxt = filt(nmi_sync_r, nmi_r);
        test_n_nxt = filt(test_sync_r, test_n_r);
        nmi_prev_nxt = nmi_r;
    end

    // nmi latch; a new edge wins over the acknowledge
    always_comb begin
        nmi_latch_nxt = nmi_latch_r;
        if (nmi_ack_i) begin
            nmi_latch_nxt = BIT_CLR;
        end
        if (nmi_rise) begin
            nmi_latch_nxt = BIT_SET; // [RULE8]
        end
        if (in_reset) begin
            nmi_latch_nxt = BIT_CLR;
        end
    end

    // reset indicator and test-mode float capture
    always_comb begin
        reset_out_nxt = in_reset; // [RULE7]
        float_nxt = float_r;
        if (in_reset) begin
            float_nxt = !test_n_r; // [RULE9]
        end
    end

    // power-down sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_RUN: begin
                if (halt_exec_i && powerdown_enable_bit_i) begin
                    state_nxt = ST_PDOWN; // [RULE1]
                end
            end
            ST_PDOWN: begin
                if (nmi_rise || nmi_latch_r) begin
                    state_nxt = ST_WAKE; // [RULE2]
                    cnt_nxt = WAKE_LOAD; // [RULE3]
                end
            end
            ST_WAKE: begin
                if (cnt_r <= CNT_ONE) begin
                    state_nxt = ST_RUN; // [RULE3]
                    cnt_nxt = CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            default: begin
                state_nxt = ST_RUN;
                cnt_nxt = CNT_ZERO;
            end
        endcase
        if (in_reset) begin
            state_nxt = ST_RUN; // [RULE4] [RULE2]
            cnt_nxt = CNT_ZERO;
        end
    end

    // registers
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            resin_sync_r <= SYNC_RESET;
            nmi_sync_r <= SYNC_RESET;
            test_sync_r <= SYNC_HIGH;
            resin_n_r <= BIT_CLR;
            nmi_r <= BIT_CLR;
            test_n_r <= BIT_SET;
            nmi_prev_r <= BIT_CLR;
            nmi_latch_r <= BIT_CLR;
            float_r <= BIT_CLR;
            reset_out_r <= BIT_SET;
            state_r <= ST_RUN;
            cnt_r <= CNT_ZERO;
        end else begin
            resin_sync_r <= resin_sync_nxt;
            nmi_sync_r <= nmi_sync_nxt;
            test_sync_r <= test_sync_nxt;
            resin_n_r <= resin_n_nxt;
            nmi_r <= nmi_nxt;
            test_n_r <= test_n_nxt;
            nmi_prev_r <= nmi_prev_nxt;
            nmi_latch_r <= nmi_latch_nxt;
            float_r <= float_nxt;
            reset_out_r <= reset_out_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // outputs; abort and init follow the filtered reset directly
    assign bus_abort_o = in_reset; // [RULE5]
    assign core_init_o = in_reset; // [RULE5] [RULE6]
    assign reset_out_o = reset_out_r || in_reset; // [RULE6] [RULE7]
    assign core_clk_en_o = (state_r == ST_RUN); // [RULE10] [RULE3]
    assign pins_float_o = float_r; // [RULE9]
    assign nmi_pending_o = nmi_latch_r;
    assign in_powerdown_o = (state_r != ST_RUN);

    // checks
    property p_enter;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r == ST_RUN && halt_exec_i && powerdown_enable_bit_i
         && !in_reset) |=> (state_r == ST_PDOWN);
    endproperty
    a_enter: assert property (p_enter) // [RULE1]
        else $error("no power-down");

    property p_no_enter;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r == ST_RUN && !(halt_exec_i && powerdown_enable_bit_i))
        |=> (state_r == ST_RUN);
    endproperty
    a_no_enter: assert property (p_no_enter) // [RULE1]
        else $error("bad entry");

    property p_nmi_exit;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r == ST_PDOWN && nmi_rise && !in_reset) |=>
        (state_r == ST_WAKE && cnt_r == WAKE_LOAD);
    endproperty
    a_nmi_exit: assert property (p_nmi_exit) // [RULE2]
        else $error("no wake");

    property p_wake_gated;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r == ST_WAKE && cnt_r > CNT_ONE && !in_reset)
        |=> (state_r == ST_WAKE && !core_clk_en_o);
    endproperty
    a_wake_gated: assert property (p_wake_gated) // [RULE3]
        else $error("clk on");

    property p_rst_exit;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r != ST_RUN && !resin_n_r) |=> (state_r == ST_RUN);
    endproperty
    a_rst_exit: assert property (p_rst_exit) // [RULE4]
        else $error("delay");

    property p_abort;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !resin_n_r |-> (bus_abort_o && core_init_o)
        ##1 (state_r == ST_RUN && !nmi_pending_o);
    endproperty
    a_abort: assert property (p_abort) // [RULE5]
        else $error("no abort");

    property p_resout;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !resin_n_r |-> reset_out_o;
    endproperty
    a_resout: assert property (p_resout) // [RULE7]
        else $error("no resout");

    property p_resout_drop;
        @(posedge core_clk_i) disable iff (!rstn_i)
        $rose(resin_n_r) |=> !reset_out_o;
    endproperty
    a_resout_drop: assert property (p_resout_drop) // [RULE6]
        else $error("stuck");

    property p_latch;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (nmi_rise && !in_reset) |=> nmi_pending_o;
    endproperty
    a_latch: assert property (p_latch) // [RULE8]
        else $error("nmi lost");

    property p_float;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (!resin_n_r && !test_n_r) |=> pins_float_o;
    endproperty
    a_float: assert property (p_float) // [RULE9]
        else $error("no float");

    property p_gated;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (state_r == ST_PDOWN && !nmi_rise && !nmi_latch_r && !in_reset)
        |=> (state_r == ST_PDOWN && !core_clk_en_o);
    endproperty
    a_gated: assert property (p_gated) // [RULE10]
        else $error("left pdown");

    c_wake: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_r == ST_WAKE ##1 state_r == ST_RUN);
    c_rst_pd: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        state_r == ST_PDOWN && !resin_n_r);
    c_float: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(pins_float_o));
endmodule

// [bench/reset_delay_model.sv]
// board side: reset source, nmi source and test-mode strap
module reset_delay_model (
    input wire logic clk_i, // bench clock
    output logic resin_n_o, // board reset line, active low
    output logic nmi_o, // interrupt line, active high
    output logic test_mode_n_o // test-mode strap, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial begin
        resin_n_o = 1'h1;
        nmi_o = 1'h0;
        test_mode_n_o = 1'h1;
    end
    // reset low for n cycles; strap outlasts the synchroniser lag
    task automatic hold_reset(input int n, input logic tm_low);
        test_mode_n_o = !tm_low;
        resin_n_o = 1'h0;
        repeat (n) @(negedge clk_i);
        resin_n_o = 1'h1;
        repeat (4) @(negedge clk_i);
        test_mode_n_o = 1'h1;
    endtask
    // short nmi pulse, long enough to pass the input filter
    task automatic pulse_nmi(input int n);
        nmi_o = 1'h1;
        repeat (n) @(negedge clk_i);
        nmi_o = 1'h0;
    endtask
endmodule

// [bench/powerdown_reset_sequencer_test.sv]
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module powerdown_reset_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WK = 12;
    typedef struct {string nm; int sel; logic [31:0] e;} note_t;
    note_t notes[$];
    note_t nt;
    logic [31:0] got;
    int checked = 0, n_fail = 0, span = 0, seed, len;
    logic core_clk_i = 1'h0, rstn_i = 1'h0;
    logic pd_en = 1'h0, halt = 1'h0, ack = 1'h0;
    logic resin_n, nmi, tm_n;
    logic clk_en, abort, init, rst_out, flt, pend, in_pd;
    logic [6:0] obs;
    assign obs = {in_pd, pend, flt, rst_out, init, abort, clk_en};
    always #5 core_clk_i = ~core_clk_i;
    reset_delay_model u_reset_delay_model (.clk_i(core_clk_i),
        .resin_n_o(resin_n), .nmi_o(nmi), .test_mode_n_o(tm_n));
    powerdown_reset_sequencer #(.WAKE_COUNT(WK)) u_powerdown_reset_sequencer (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .resin_n_i(resin_n),
        .nmi_i(nmi), .test_mode_n_i(tm_n), .powerdown_enable_bit_i(pd_en),
        .halt_exec_i(halt), .nmi_ack_i(ack), .core_clk_en_o(clk_en),
        .bus_abort_o(abort), .core_init_o(init), .reset_out_o(rst_out),
        .pins_float_o(flt), .nmi_pending_o(pend), .in_powerdown_o(in_pd));
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    // sel 0..6 picks an output bit, sel 7 the measured span
    task automatic note(input string nm, input int s, input logic [31:0] e);
        notes.push_back('{nm, s, e});
    endtask
    task automatic wait_on(input int s, input logic v, input int mx);
        span = 0;
        while (obs[s] !== v && span < mx) begin
            tk(1);
            span++;
        end
        if (span >= mx) begin
            n_fail++;
            $display("BAD wait_on sel %0d exp %0h got %0h", s, v, obs[s]);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watcher: settled outputs against the oldest notes
    always @(negedge core_clk_i) begin
        #2;
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            got = (nt.sel == 7) ? span : {31'h0, obs[nt.sel]};
            `CHK(nt.nm, nt.e, got)
        end
    end
    // watchdog, far beyond the fewer than two hundred cycles of the run
    initial begin
        #100us;
        n_fail++;
        give_verdict();
    end
    initial begin
        seed = 71760;
        tk(8);
        note("rst_out", 3, 1);
        note("abort", 1, 1);
        note("init", 2, 1);
        note("float", 4, 0);
        rstn_i = 1'h1;
        tk(6);
        note("rst_out", 3, 0);
        $display("test reset done");
        halt = 1'h1;
        tk(1);
        halt = 1'h0;
        tk(2);
        note("in_pd", 6, 0);
        note("clk_en", 0, 1);
        pd_en = 1'h1;
        halt = 1'h1;
        tk(1);
        halt = 1'h0;
        tk(2 + ($random(seed) & 7));
        note("in_pd", 6, 1);
        note("clk_en", 0, 0);
        len = 4 + ($random(seed) & 3);
        // pulse runs beside the watch so the span starts at the wake edge
        fork
            u_reset_delay_model.pulse_nmi(len);
        join_none
        wait_on(5, 1'h1, 20);
        note("pend", 5, 1);
        wait_on(0, 1'h1, WK + 10);
        note("wake_span", 7, WK);
        note("in_pd", 6, 0);
        ack = 1'h1;
        tk(1);
        ack = 1'h0;
        tk(1);
        note("pend", 5, 0);
        $display("test nmi wake done");
        halt = 1'h1;
        tk(1);
        halt = 1'h0;
        tk(3);
        fork
            u_reset_delay_model.hold_reset(20, 1'h0);
            begin
                tk(8);
                note("clk_en", 0, 1);
                note("in_pd", 6, 0);
                note("abort", 1, 1);
                note("float", 4, 0);
                tk(10);
                note("rst_out", 3, 1);
            end
        join
        tk(3);
        $display("test reset exit done");
        // nmi held from run time wakes power-down right after entry
        fork
            u_reset_delay_model.pulse_nmi(len);
        join_none
        wait_on(5, 1'h1, 20);
        note("pend", 5, 1);
        halt = 1'h1;
        tk(1);
        halt = 1'h0;
        // one cycle in power-down, then the full wake delay
        wait_on(0, 1'h1, WK + 10);
        note("latch_span", 7, WK + 1);
        tk(1);
        $display("test latch wake done");
        fork
            u_reset_delay_model.hold_reset(12, 1'h1);
            begin
                tk(9);
                note("float", 4, 1);
                note("rst_out", 3, 1);
            end
        join
        tk(3);
        note("float", 4, 1);
        tk(1);
        $display("test float done");
        give_verdict();
    end
endmodule
